/* File: common/isl_pkg.sv */
package isl_pkg;

  // ==========================================================
  // Geometry
  localparam int ISL_LANES = 4;
  localparam int ISL_TAGS = 16;
  localparam int ISL_TAG_W = 4;
  localparam int ISL_CNT_W = 5;
  localparam int ISL_LUT_N = 81;

  // ==========================================================
  // Slot classes, base-3 digits, ordered E < L < U
  localparam logic [1:0] ISL_SC_E = 2'h0;
  localparam logic [1:0] ISL_SC_L = 2'h1;
  localparam logic [1:0] ISL_SC_U = 2'h2;
  localparam logic [6:0] ISL_W3 = 7'h1b;
  localparam logic [6:0] ISL_W2 = 7'h09;
  localparam logic [6:0] ISL_W1 = 7'h03;

  // Slotting per pattern, bit p set means position p goes upper
  localparam logic [3:0] ISL_SLOT_LUT [ISL_LUT_N] = '{
    4'ha, 4'ha, 4'h9, 4'h9, 4'hc, 4'h9, 4'ha, 4'ha, 4'h3,
    4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h9, 4'ha, 4'ha, 4'h3,
    4'h5, 4'h6, 4'h5, 4'h5, 4'hc, 4'h5, 4'h6, 4'h6, 4'h7,
    4'h5, 4'h6, 4'h5, 4'h5, 4'h4, 4'h5, 4'h6, 4'h6, 4'h3,
    4'h3, 4'h2, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h2, 4'h3,
    4'h5, 4'h6, 4'h5, 4'h5, 4'h4, 4'h5, 4'h6, 4'h6, 4'h7,
    4'ha, 4'ha, 4'h9, 4'h9, 4'hc, 4'h9, 4'ha, 4'ha, 4'hb,
    4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h9, 4'ha, 4'ha, 4'hb,
    4'hc, 4'hc, 4'hd, 4'hc, 4'hc, 4'hd, 4'he, 4'he, 4'hf
  };

  // ==========================================================
  // Instruction classes
  typedef enum logic [4:0] {
    ISL_CL_ILD = 5'h00,
    ISL_CL_FLD = 5'h01,
    ISL_CL_IST = 5'h02,
    ISL_CL_FST = 5'h03,
    ISL_CL_RPCC = 5'h04,
    ISL_CL_RX = 5'h05,
    ISL_CL_PRIV_REG_READ = 5'h06,
    ISL_CL_PRIV_REG_WRITE = 5'h07,
    ISL_CL_IBR = 5'h08,
    ISL_CL_UBR = 5'h09,
    ISL_CL_JSR = 5'h0a,
    ISL_CL_IADD = 5'h0b,
    ISL_CL_ILOG = 5'h0c,
    ISL_CL_ISHF = 5'h0d,
    ISL_CL_INT_CMOVE_FIRST_HALF = 5'h0e,
    ISL_CL_INT_CMOVE_SECOND_HALF = 5'h0f,
    ISL_CL_IMUL = 5'h10,
    ISL_CL_IMISC = 5'h11,
    ISL_CL_FBR = 5'h12,
    ISL_CL_FADD = 5'h13,
    ISL_CL_FTOI = 5'h14
  } isl_class_t;

  // ==========================================================
  // Result latencies in cycles
  localparam logic [4:0] ISL_LAT_ILD_HIT = 5'h03;
  localparam logic [4:0] ISL_LAT_FLD_HIT = 5'h04;
  localparam logic [4:0] ISL_LAT_ILD_MISS = 5'h0d;
  localparam logic [4:0] ISL_LAT_FLD_MISS = 5'h0e;
  localparam logic [4:0] ISL_LAT_RPCC = 5'h01;
  localparam logic [4:0] ISL_LAT_RX = 5'h01;
  localparam logic [4:0] ISL_LAT_PRR_EBOX = 5'h01;
  localparam logic [4:0] ISL_LAT_PRR_OTHER = 5'h03;
  localparam logic [4:0] ISL_LAT_UBR = 5'h03;
  localparam logic [4:0] ISL_LAT_JSR = 5'h03;
  localparam logic [4:0] ISL_LAT_ISIMPLE = 5'h01;
  localparam logic [4:0] ISL_LAT_IMUL = 5'h07;
  localparam logic [4:0] ISL_LAT_IMISC = 5'h03;
  localparam logic [4:0] ISL_LAT_FADD = 5'h04;
  localparam logic [4:0] ISL_LAT_FADD_FI = 5'h06;
  localparam logic [4:0] ISL_LAT_FTOI = 5'h03;
  localparam logic [4:0] ISL_LAT_XC = 5'h01;
  localparam logic [4:0] ISL_CNT_MAX = 5'h1f;
  localparam logic [4:0] ISL_CNT_ZERO = 5'h00;
  localparam logic [4:0] ISL_CNT_ONE = 5'h01;

  // Per-producer timing record
  typedef struct packed {
    logic prod;
    logic xc;
    logic cm1;
    logic [4:0] lat;
    logic [4:0] fi;
  } isl_lat_t;

endpackage

/* File: logic/isl_lat_cnt.sv */
`timescale 1ns/1ps
// ============================================================
// Per-tag result timer
module isl_lat_cnt
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Producer issue
  input wire logic load,
  input wire isl_pkg::isl_lat_t load_info,
  input wire logic load_cl,
  // Load miss and fill
  input wire logic miss_set,
  input wire logic [4:0] miss_lat,
  input wire logic fill,
  // State
  output logic busy_ff,
  output logic pend_ff,
  output logic [4:0] elap_ff,
  output isl_pkg::isl_lat_t info_ff,
  output logic cl_ff
);

  logic nxt_busy;
  logic nxt_pend;
  logic [4:0] nxt_elap;
  isl_lat_t nxt_info;
  logic nxt_cl;

  // Next state; a new producer simply overwrites the old one
  always_comb
  begin
    nxt_busy = busy_ff;
    nxt_pend = pend_ff;
    nxt_info = info_ff;
    nxt_cl = cl_ff;
    nxt_elap = (elap_ff == ISL_CNT_MAX) ? elap_ff : elap_ff + ISL_CNT_ONE;
    if (load)
    begin
      nxt_busy = load_info.prod;
      nxt_pend = 1'b0;
      nxt_info = load_info;
      nxt_cl = load_cl;
      // Count from one so a latency-one result feeds the very next cycle
      nxt_elap = ISL_CNT_ONE;
    end
    else
    begin
      // Miss set wins over a fill in the same cycle
      if (fill)
        nxt_pend = 1'b0;
      if (miss_set && busy_ff)
      begin
        nxt_pend = 1'b1;
        nxt_info.lat = miss_lat;
      end
    end
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      pend_ff <= 1'b0;
      elap_ff <= ISL_CNT_ZERO;
      info_ff <= '0;
      cl_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= nxt_busy;
      pend_ff <= nxt_pend;
      elap_ff <= nxt_elap;
      info_ff <= nxt_info;
      cl_ff <= nxt_cl;
    end
  end

endmodule

/* File: logic/isl_top.sv */
`timescale 1ns/1ps
// How it works
// - At map, either-class instructions get upper or lower by line mix.
// - Classes are upper-only, lower-only, either; fixed ones keep their side.
// - Slot position in the line comes from PC bits 3:2, order 3,2,1,0.
// - A fixed 81-entry table maps the class pattern to sides.
// - Issue waits for operands ready, unit free, and queue order.
// - Renaming removes write-after-write; only true and unit deps tracked.
// - Latencies are fixed except loads missing the data cache.
// - Loads: int 3, fp 4 on hit; at least 13 or 14 on miss.
// - Stores, fp branches, privileged writes wake no consumer.
// - Cycle counter read gives result in 1, plus cross-cluster cycle.
// - Privileged read takes 1 for integer-unit registers, 3 otherwise.
// - Int conditional branch no result; jumps give return address in 3.
// - Add, logic, shift, cmove 1; misc 3; multiply 7; plus crossing.
// - First cmove half feeds only its second half.
// - Fp add 4 to ordinary consumers, 6 to fp store or fp-to-int.
// - Operands read the stage after issue; execute starts the next.
module isl_top
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch line into the mapper
  input wire logic map_valid,
  input wire logic [3:0] map_instr_valid,
  input wire logic [7:0] map_pc_bits,
  input wire logic [7:0] map_slot_class,
  // Slotting result
  output logic slot_valid_ff,
  output logic [3:0] slot_upper_ff,
  output logic [3:0] slot_line_ff,
  // Issue candidate from the queue
  input wire logic iss_valid,
  input wire isl_pkg::isl_class_t iss_class,
  input wire logic iss_priv_reg_int,
  input wire logic iss_cluster,
  input wire logic iss_fu_free,
  input wire logic iss_older_block,
  input wire logic [3:0] iss_dest_tag,
  input wire logic iss_src_a_use,
  input wire logic [3:0] iss_src_a_tag,
  input wire logic iss_src_b_use,
  input wire logic [3:0] iss_src_b_tag,
  // Issue answer
  output logic iss_grant,
  // Load miss and fill
  input wire logic ld_miss_valid,
  input wire logic [3:0] ld_miss_tag,
  input wire logic ld_miss_fp,
  input wire logic ld_fill_valid,
  input wire logic [3:0] ld_fill_tag,
  // Pipeline stages after issue
  output logic rr_valid_ff,
  output logic [3:0] rr_dest_ff,
  output logic ex_valid_ff,
  output logic [3:0] ex_dest_ff
);

  // ==========================================================
  // Slotting
  logic [1:0] pat [ISL_LANES];
  logic [6:0] lut_idx;
  logic [3:0] lut_out;
  logic nxt_slot_valid;
  logic [3:0] nxt_slot_upper;
  logic [3:0] nxt_slot_line;

  // Place each instruction at its line position; holes act as either
  always_comb
  begin
    for (int p = 0; p < ISL_LANES; p++)
      pat[p] = ISL_SC_E;
    for (int i = 0; i < ISL_LANES; i++)
      if (map_instr_valid[i])
        pat[map_pc_bits[2*i +: 2]] = map_slot_class[2*i +: 2];
    lut_idx = 7'(pat[3] * ISL_W3) + 7'(pat[2] * ISL_W2)
            + 7'(pat[1] * ISL_W1) + 7'(pat[0]);
    lut_out = ISL_SLOT_LUT[lut_idx];
  end

  // Side per instruction; fixed classes keep their side, and an invalid lane reads lower
  always_comb
  begin
    nxt_slot_valid = map_valid;
    nxt_slot_line = lut_out;
    for (int i = 0; i < ISL_LANES; i++)
    begin
      case (map_slot_class[2*i +: 2])
        ISL_SC_U: nxt_slot_upper[i] = 1'b1;
        ISL_SC_L: nxt_slot_upper[i] = 1'b0;
        default: nxt_slot_upper[i] = lut_out[map_pc_bits[2*i +: 2]];
      endcase
      if (!map_instr_valid[i])
        nxt_slot_upper[i] = 1'b0;
    end
  end

  // Slot registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slot_valid_ff <= 1'b0;
      slot_upper_ff <= 4'h0;
      slot_line_ff <= 4'h0;
    end
    else
    begin
      slot_valid_ff <= nxt_slot_valid;
      slot_upper_ff <= nxt_slot_upper;
      slot_line_ff <= nxt_slot_line;
    end
  end

  // ==========================================================
  // Class timing
  function automatic isl_lat_t lat_of(input isl_class_t c,
                                      input logic ebox);
    isl_lat_t r;
    r = '0;
    r.prod = 1'b1;
    case (c)
      ISL_CL_ILD: r.lat = ISL_LAT_ILD_HIT;
      ISL_CL_FLD: r.lat = ISL_LAT_FLD_HIT;
      ISL_CL_RPCC:
      begin
        r.lat = ISL_LAT_RPCC;
        r.xc = 1'b1;
      end
      ISL_CL_RX: r.lat = ISL_LAT_RX;
      ISL_CL_PRIV_REG_READ:
        r.lat = ebox ? ISL_LAT_PRR_EBOX : ISL_LAT_PRR_OTHER;
      ISL_CL_UBR: r.lat = ISL_LAT_UBR;
      ISL_CL_JSR: r.lat = ISL_LAT_JSR;
      ISL_CL_IADD, ISL_CL_ILOG, ISL_CL_ISHF,
      ISL_CL_INT_CMOVE_SECOND_HALF:
      begin
        r.lat = ISL_LAT_ISIMPLE;
        r.xc = 1'b1;
      end
      ISL_CL_INT_CMOVE_FIRST_HALF:
      begin
        r.lat = ISL_LAT_ISIMPLE;
        r.xc = 1'b1;
        r.cm1 = 1'b1;
      end
      ISL_CL_IMUL:
      begin
        r.lat = ISL_LAT_IMUL;
        r.xc = 1'b1;
      end
      ISL_CL_IMISC:
      begin
        r.lat = ISL_LAT_IMISC;
        r.xc = 1'b1;
      end
      ISL_CL_FADD:
      begin
        r.lat = ISL_LAT_FADD;
        r.fi = ISL_LAT_FADD_FI;
      end
      ISL_CL_FTOI: r.lat = ISL_LAT_FTOI;
      default: r.prod = 1'b0;
    endcase
    // Fixed latency holds for any consumer unless a longer one is given
    if (r.fi == ISL_CNT_ZERO)
      r.fi = r.lat;
    return r;
  endfunction

  // ==========================================================
  // Scoreboard, one timer per rename tag
  logic [ISL_TAGS-1:0] busy;
  logic [ISL_TAGS-1:0] pend;
  logic [ISL_TAGS-1:0] pcl;
  logic [4:0] elap [ISL_TAGS];
  isl_lat_t info [ISL_TAGS];
  isl_lat_t iss_info;
  logic [4:0] miss_lat;

  assign iss_info = lat_of(iss_class, iss_priv_reg_int);
  assign miss_lat = ld_miss_fp ? ISL_LAT_FLD_MISS : ISL_LAT_ILD_MISS;

  // Only true dependencies are kept; a rewrite of a tag replaces it
  for (genvar t = 0; t < ISL_TAGS; t++)
  begin : g_tag
    isl_lat_cnt u_cnt (
      .clk(clk),
      .rst(rst),
      .load(iss_grant && iss_dest_tag == ISL_TAG_W'(t)),
      .load_info(iss_info),
      .load_cl(iss_cluster),
      .miss_set(ld_miss_valid && ld_miss_tag == ISL_TAG_W'(t)),
      .miss_lat(miss_lat),
      .fill(ld_fill_valid && ld_fill_tag == ISL_TAG_W'(t)),
      .busy_ff(busy[t]),
      .pend_ff(pend[t]),
      .elap_ff(elap[t]),
      .info_ff(info[t]),
      .cl_ff(pcl[t])
    );
  end

  // ==========================================================
  // Operand readiness and issue
  function automatic logic src_ok(input logic [3:0] tag);
    logic [4:0] need;
    logic ok;
    need = (iss_class == ISL_CL_FST || iss_class == ISL_CL_FTOI)
         ? info[tag].fi : info[tag].lat;
    if (info[tag].xc && pcl[tag] != iss_cluster)
      need = need + ISL_LAT_XC;
    ok = !pend[tag] && elap[tag] >= need;
    if (info[tag].cm1 && iss_class != ISL_CL_INT_CMOVE_SECOND_HALF)
      ok = 1'b0;
    return !busy[tag] || ok;
  endfunction

  // Combinational grant; a missing load blocks until its fill
  always_comb
  begin
    iss_grant = iss_valid && iss_fu_free && !iss_older_block
             && (!iss_src_a_use || src_ok(iss_src_a_tag))
             && (!iss_src_b_use || src_ok(iss_src_b_tag));
  end

  // ==========================================================
  // Register read then execute stages
  logic nxt_rr_valid;
  logic [3:0] nxt_rr_dest;
  logic nxt_ex_valid;
  logic [3:0] nxt_ex_dest;

  // Issue moves to register read, then to execute
  always_comb
  begin
    nxt_rr_valid = iss_grant;
    nxt_rr_dest = iss_grant ? iss_dest_tag : rr_dest_ff;
    nxt_ex_valid = rr_valid_ff;
    nxt_ex_dest = rr_valid_ff ? rr_dest_ff : ex_dest_ff;
  end

  // Stage registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rr_valid_ff <= 1'b0;
      rr_dest_ff <= 4'h0;
      ex_valid_ff <= 1'b0;
      ex_dest_ff <= 4'h0;
    end
    else
    begin
      rr_valid_ff <= nxt_rr_valid;
      rr_dest_ff <= nxt_rr_dest;
      ex_valid_ff <= nxt_ex_valid;
      ex_dest_ff <= nxt_ex_dest;
    end
  end

endmodule

/* File: tb/isl_map_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Mapper model: presents a requested line for one cycle
module isl_map_model (
  // Clock and bench request
  input wire logic clk,
  input wire logic line_req,
  input wire logic [3:0] line_vld,
  input wire logic [7:0] line_pc,
  input wire logic [7:0] line_cls,
  // Fetch line to the block
  output logic map_valid,
  output logic [3:0] map_instr_valid,
  output logic [7:0] map_pc_bits,
  output logic [7:0] map_slot_class
);
  logic take;
  initial map_pc_bits = 8'h00;
  initial map_slot_class = 8'h00;
  // Outside a line the fields flip so stale values never match
  always @(posedge clk)
  begin
    take = line_req;
    #1;
    map_valid = take;
    map_instr_valid = take ? line_vld : 4'h0;
    map_pc_bits = take ? line_pc : ~map_pc_bits;
    map_slot_class = take ? line_cls : ~map_slot_class;
  end
endmodule

/* File: tb/isl_top_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Checker on the top-level ports
module isl_top_props
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Slotting
  input wire logic map_valid,
  input wire logic [3:0] map_instr_valid,
  input wire logic [7:0] map_pc_bits,
  input wire logic [7:0] map_slot_class,
  input wire logic slot_valid_ff,
  input wire logic [3:0] slot_upper_ff,
  input wire logic [3:0] slot_line_ff,
  // Issue and stages
  input wire logic iss_valid,
  input wire isl_pkg::isl_class_t iss_class,
  input wire logic iss_fu_free,
  input wire logic iss_older_block,
  input wire logic [3:0] iss_dest_tag,
  input wire logic iss_src_a_use,
  input wire logic [3:0] iss_src_a_tag,
  input wire logic iss_grant,
  input wire logic rr_valid_ff,
  input wire logic [3:0] rr_dest_ff,
  input wire logic ex_valid_ff,
  input wire logic [3:0] ex_dest_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] mul_tag_ff, cm_tag_ff;
  logic [4:0] mul_age_ff;
  logic cm_live_ff;
  // Age of the last multiply; a rewrite of its tag ends the watch
  always_ff @(posedge clk)
  begin
    if (rst)
      mul_age_ff <= 5'h1f;
    else if (iss_grant && iss_class == ISL_CL_IMUL)
      mul_age_ff <= 5'h01;
    else if (iss_grant && iss_dest_tag == mul_tag_ff)
      mul_age_ff <= 5'h1f;
    else if (mul_age_ff != 5'h1f)
      mul_age_ff <= mul_age_ff + 5'h01;
    if (iss_grant && iss_class == ISL_CL_IMUL)
      mul_tag_ff <= iss_dest_tag;
  end
  // Live first cmove half, watched until its tag is rewritten
  always_ff @(posedge clk)
  begin
    if (rst)
      cm_live_ff <= 1'b0;
    else if (iss_grant && iss_class == ISL_CL_INT_CMOVE_FIRST_HALF)
      cm_live_ff <= 1'b1;
    else if (iss_grant && iss_dest_tag == cm_tag_ff)
      cm_live_ff <= 1'b0;
    if (iss_grant && iss_class == ISL_CL_INT_CMOVE_FIRST_HALF)
      cm_tag_ff <= iss_dest_tag;
  end
  property p_slot_valid;
    !$past(rst) |-> slot_valid_ff == $past(map_valid);
  endproperty
  a_slot_valid: assert property (p_slot_valid)
    else $error("slot valid not a copy of map valid");
  property p_upper_kept;
    !$past(rst) && $past(map_instr_valid[3] &&
      map_slot_class[7:6] == ISL_SC_U) |-> slot_upper_ff[3];
  endproperty
  a_upper_kept: assert property (p_upper_kept)
    else $error("upper-only lane placed lower");
  property p_lower_kept;
    !$past(rst) && $past(map_instr_valid[2] &&
      map_slot_class[5:4] == ISL_SC_L) |-> !slot_upper_ff[2];
  endproperty
  a_lower_kept: assert property (p_lower_kept)
    else $error("lower-only lane placed upper");
  property p_pos_map;
    !$past(rst) && $past(map_instr_valid[3]) |->
      slot_upper_ff[3] == slot_line_ff[$past(map_pc_bits[7:6])];
  endproperty
  a_pos_map: assert property (p_pos_map)
    else $error("lane side differs from its position");
  property p_grant_cond;
    iss_grant |-> iss_valid && iss_fu_free && !iss_older_block;
  endproperty
  a_grant_cond: assert property (p_grant_cond)
    else $error("grant without valid, free unit or order");
  property p_rr_stage;
    iss_grant |=> rr_valid_ff && rr_dest_ff == $past(iss_dest_tag);
  endproperty
  a_rr_stage: assert property (p_rr_stage)
    else $error("register read stage missing after grant");
  property p_ex_stage;
    rr_valid_ff |=> ex_valid_ff && ex_dest_ff == $past(rr_dest_ff);
  endproperty
  a_ex_stage: assert property (p_ex_stage)
    else $error("execute stage missing after read");
  property p_mul_wait;
    iss_grant && iss_src_a_use && iss_src_a_tag == mul_tag_ff &&
      mul_age_ff != 5'h1f |-> mul_age_ff >= 5'h07;
  endproperty
  a_mul_wait: assert property (p_mul_wait)
    else $error("multiply consumer issued early");
  property p_cm_only;
    iss_grant && cm_live_ff && iss_src_a_use && iss_src_a_tag ==
      cm_tag_ff |-> iss_class == ISL_CL_INT_CMOVE_SECOND_HALF;
  endproperty
  a_cm_only: assert property (p_cm_only)
    else $error("first cmove half fed another consumer");
  c_line: cover property (map_valid && map_instr_valid == 4'hf);
  c_held: cover property (iss_valid && !iss_grant);
  c_cm: cover property (cm_live_ff && iss_grant);
endmodule

/* File: tb/tb_isl_top.sv */
`timescale 1ns/1ps
module tb_isl_top;
  import isl_pkg::*;
  // ==========================================================
  // Signals
  logic clk = 1'b0, rst = 1'b1, line_req = 1'b0;
  logic [3:0] line_vld = 4'h0;
  logic [7:0] line_pc = 8'h00, line_cls = 8'h00;
  logic map_valid, slot_valid_ff, iss_grant, rr_valid_ff, ex_valid_ff;
  logic [3:0] map_instr_valid, slot_upper_ff, slot_line_ff;
  logic [7:0] map_pc_bits, map_slot_class;
  logic [3:0] rr_dest_ff, ex_dest_ff;
  logic iss_valid = 1'b0, iss_priv_reg_int = 1'b0, iss_cluster = 1'b0;
  logic iss_fu_free = 1'b1, iss_older_block = 1'b0;
  logic iss_src_a_use = 1'b0, iss_src_b_use = 1'b0;
  logic [3:0] iss_dest_tag = 4'h0, iss_src_a_tag = 4'h0;
  logic [3:0] iss_src_b_tag = 4'h0;
  isl_class_t iss_class = ISL_CL_IADD;
  logic ld_miss_valid = 1'b0, ld_miss_fp = 1'b0, ld_fill_valid = 1'b0;
  logic [3:0] ld_miss_tag = 4'h5, ld_fill_tag = 4'h5;
  int n_mismatch = 0, n_compared = 0;
  always #50 clk = ~clk;
  isl_map_model u_map (.clk, .line_req, .line_vld, .line_pc, .line_cls,
    .map_valid, .map_instr_valid, .map_pc_bits, .map_slot_class);
  isl_top u_dut (.clk, .rst, .map_valid, .map_instr_valid, .map_pc_bits,
    .map_slot_class, .slot_valid_ff, .slot_upper_ff, .slot_line_ff,
    .iss_valid, .iss_class, .iss_priv_reg_int, .iss_cluster, .iss_fu_free,
    .iss_older_block, .iss_dest_tag, .iss_src_a_use, .iss_src_a_tag,
    .iss_src_b_use, .iss_src_b_tag, .iss_grant, .ld_miss_valid,
    .ld_miss_tag, .ld_miss_fp, .ld_fill_valid, .ld_fill_tag,
    .rr_valid_ff, .rr_dest_ff, .ex_valid_ff, .ex_dest_ff);
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic line(input logic [7:0] cls, pc, input logic [3:0] v, ln, up);
    line_req = 1'b1;
    line_cls = cls;
    line_pc = pc;
    line_vld = v;
    tick;
    line_req = 1'b0;
    tick;
    check(slot_valid_ff, 8'h01);
    check(slot_line_ff, ln);
    check(slot_upper_ff, up);
  endtask
  task automatic drv(input isl_class_t c, input logic [3:0] dst,
    input logic au);
    iss_valid = 1'b1;
    iss_class = c;
    iss_dest_tag = dst;
    iss_src_a_use = au;
    iss_src_a_tag = 4'h5;
  endtask
  // Producer on tag 5, then a consumer retried until granted or 29 cycles
  task automatic probe(input isl_class_t pc, input int exp,
    input isl_class_t cc = ISL_CL_IADD, input logic xc = 1'b0,
    input logic eb = 1'b0, input int fill = 0);
    int n;
    iss_priv_reg_int = eb;
    iss_cluster = xc;
    ld_miss_fp = (pc == ISL_CL_FLD);
    drv(pc, 4'h5, 1'b0);
    #10;
    check(iss_grant, 8'h01);
    for (n = 1; n < 30; n++)
    begin
      tick;
      iss_cluster = 1'b0;
      ld_miss_valid = (n == 1 && fill > 0);
      ld_fill_valid = (n == fill);
      drv(cc, 4'h9, 1'b1);
      #10;
      if (iss_grant === 1'b1)
        break;
    end
    check(8'(n), 8'(exp));
    tick;
    iss_valid = 1'b0;
    ld_miss_valid = 1'b0;
    ld_fill_valid = 1'b0;
    tick;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_slotting;
    line(8'h00, 8'he4, 4'hf, 4'ha, 4'ha);
    line(8'h1a, 8'he4, 4'hf, 4'h3, 4'h3);
    line(8'h0a, 8'he4, 4'hf, 4'h3, 4'h3);
    line(8'h61, 8'he4, 4'hf, 4'h6, 4'h6);
    line(8'h25, 8'he4, 4'hf, 4'hc, 4'hc);
    line(8'h55, 8'he4, 4'hf, 4'h0, 4'h0);
    line(8'haa, 8'he4, 4'hf, 4'hf, 4'hf);
    line(8'h8a, 8'he4, 4'hf, 4'hb, 4'hb);
    line(8'h40, 8'h1b, 4'hf, 4'ha, 4'h5);
    line(8'h42, 8'h1b, 4'he, 4'ha, 4'h4);
  endtask
  // Refusals one at a time, with the stages after a grant
  task automatic t_refuse;
    drv(ISL_CL_IMUL, 4'h6, 1'b0);
    #10;
    check(iss_grant, 8'h01);
    tick;
    check(rr_dest_ff, 8'h06);
    iss_src_b_use = 1'b1;
    iss_src_b_tag = 4'h6;
    drv(ISL_CL_IADD, 4'h9, 1'b0);
    #10;
    check(iss_grant, 8'h00);
    tick;
    check(ex_dest_ff, 8'h06);
    iss_src_b_use = 1'b0;
    iss_fu_free = 1'b0;
    #10;
    check(iss_grant, 8'h00);
    tick;
    check(rr_valid_ff, 8'h00);
    iss_fu_free = 1'b1;
    iss_older_block = 1'b1;
    #10;
    check(iss_grant, 8'h00);
    tick;
    iss_older_block = 1'b0;
    iss_valid = 1'b0;
    #10;
    check(iss_grant, 8'h00);
    tick;
    iss_valid = 1'b1;
    #10;
    check(iss_grant, 8'h01);
    tick;
    iss_valid = 1'b0;
    tick;
  endtask
  task automatic t_latency;
    probe(ISL_CL_ILD, 3);
    probe(ISL_CL_FLD, 4);
    probe(ISL_CL_ILD, 13, ISL_CL_IADD, 1'b0, 1'b0, 5);
    probe(ISL_CL_FLD, 14, ISL_CL_IADD, 1'b0, 1'b0, 5);
    probe(ISL_CL_ILD, 21, ISL_CL_IADD, 1'b0, 1'b0, 20);
    probe(ISL_CL_RPCC, 1);
    probe(ISL_CL_RPCC, 2, ISL_CL_IADD, 1'b1);
    probe(ISL_CL_RX, 1);
    probe(ISL_CL_PRIV_REG_READ, 1, ISL_CL_IADD, 1'b0, 1'b1);
    probe(ISL_CL_PRIV_REG_READ, 3);
    probe(ISL_CL_UBR, 3);
    probe(ISL_CL_JSR, 3);
    probe(ISL_CL_IADD, 1);
    probe(ISL_CL_ILOG, 1);
    probe(ISL_CL_ISHF, 1);
    probe(ISL_CL_IMISC, 3);
    probe(ISL_CL_IMUL, 7);
    probe(ISL_CL_IMUL, 8, ISL_CL_IADD, 1'b1);
    probe(ISL_CL_IADD, 2, ISL_CL_IADD, 1'b1);
    probe(ISL_CL_FADD, 4);
    probe(ISL_CL_FADD, 6, ISL_CL_FST);
    probe(ISL_CL_FADD, 6, ISL_CL_FTOI);
    probe(ISL_CL_FTOI, 3);
    probe(ISL_CL_IST, 1);
    probe(ISL_CL_FST, 1);
    probe(ISL_CL_PRIV_REG_WRITE, 1);
    probe(ISL_CL_FBR, 1);
    probe(ISL_CL_IBR, 1);
    probe(ISL_CL_INT_CMOVE_FIRST_HALF, 1,
      ISL_CL_INT_CMOVE_SECOND_HALF);
    probe(ISL_CL_INT_CMOVE_FIRST_HALF, 30);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    check(slot_valid_ff, 8'h00);
    check(rr_valid_ff, 8'h00);
    rst = 1'b0;
    t_slotting;
    t_refuse;
    t_latency;
    conclude;
  end
  initial
  begin
    #(100 * 20000);
    n_mismatch++;
    conclude;
  end
endmodule
bind isl_top isl_top_props u_props (.clk, .rst, .map_valid,
  .map_instr_valid, .map_pc_bits, .map_slot_class, .slot_valid_ff,
  .slot_upper_ff, .slot_line_ff, .iss_valid, .iss_class, .iss_fu_free,
  .iss_older_block, .iss_dest_tag, .iss_src_a_use, .iss_src_a_tag,
  .iss_grant, .rr_valid_ff, .rr_dest_ff, .ex_valid_ff, .ex_dest_ff);
